/* sdf_fifo.sv */
`timescale 1ns/1ns
`default_nettype none

module sdf_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 4
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } sdf_fifo_state_t;

    sdf_fifo_state_t q;
    sdf_fifo_state_t d;
    logic push;
    logic pop;

    assign o_in_ready = q.cnt != (AW + 1)'(DEPTH);
    assign o_out_valid = q.cnt != '0;
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_data = q.mem[q.rd];

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wr] = i_in_data;
            d.wr = (q.wr == AW'(DEPTH - 1)) ? '0 : AW'(q.wr + 1'b1);
        end
        if (pop) begin
            d.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : AW'(q.rd + 1'b1);
        end
        if (push && !pop) begin
            d.cnt = (AW + 1)'(q.cnt + 1'b1);
        end else if (pop && !push) begin
            d.cnt = (AW + 1)'(q.cnt - 1'b1);
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    a_fifo_full_stall: assert property (@(posedge i_ref_clk)
        disable iff (i_rst)
        q.cnt == (AW + 1)'(DEPTH) && !i_out_ready |=> !o_in_ready)
        else $error("fifo accepted data while full");
endmodule

`default_nettype wire

/* sdf_host_model.sv */
`timescale 1ns/1ns
`default_nettype none

// host side: pops a word whenever data-ready is low and it is not stalled;
// words read before the settling interval ends are marked unsettled
module sdf_host_model
    import sdf_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_stall,
    input wire logic i_settle_start,
    input wire logic [15:0] i_settle_cycles,
    input wire logic i_sample_ready_n,
    input wire logic [OUT_W-1:0] i_sample_data,
    output logic o_sample_ready
);
    int cyc;
    int settle_left;
    int n_got;
    int last_stamp;
    logic [OUT_W-1:0] last_word;
    logic last_settled;

    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            cyc <= 0;
            settle_left <= int'(i_settle_cycles);
            n_got <= 0;
            last_stamp <= 0;
            last_word <= 24'h00_0000;
            last_settled <= 1'b0;
            o_sample_ready <= 1'b0;
        end else begin
            cyc <= cyc + 1;
            o_sample_ready <= !i_stall;
            if (i_settle_start) begin
                settle_left <= int'(i_settle_cycles);
            end else if (settle_left > 0) begin
                settle_left <= settle_left - 1;
            end
            // a word is taken only on the edge where both sides agree
            if (!i_sample_ready_n && o_sample_ready) begin
                n_got <= n_got + 1;
                last_stamp <= cyc;
                last_word <= i_sample_data;
                last_settled <= (settle_left == 0);
            end
        end
    end
endmodule

`default_nettype wire

/* sdf_sinc3.sv */
`timescale 1ns/1ns
`default_nettype none

// three integrators at the modulator rate, three combs at the dump rate;
// 32-bit wrap-around arithmetic is exact because N^3 stays below 2^31
module sdf_sinc3 (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_restart,
    input wire logic i_mod_en,
    input wire logic i_bit,
    input wire logic i_dump,
    output logic o_valid,
    output logic signed [31:0] o_raw
);
    typedef struct packed {
        logic [2:0][31:0] integ;
        logic [2:0][31:0] dly;
        logic valid;
        logic [31:0] raw;
    } sdf_sinc3_state_t;

    sdf_sinc3_state_t q;
    sdf_sinc3_state_t d;

    always_comb begin
        logic [31:0] c0;
        logic [31:0] c1;
        logic [31:0] c2;
        d = q;
        c0 = '0;
        c1 = '0;
        c2 = '0;
        d.valid = 1'b0;
        if (i_restart) begin
            d.integ = '0;
            d.dly = '0;
        end else if (i_mod_en) begin
            d.integ[0] = i_bit ? 32'(q.integ[0] + 32'h0000_0001)
                               : 32'(q.integ[0] - 32'h0000_0001);
            d.integ[1] = 32'(q.integ[1] + d.integ[0]);
            d.integ[2] = 32'(q.integ[2] + d.integ[1]);
            if (i_dump) begin
                c0 = 32'(d.integ[2] - q.dly[0]);
                c1 = 32'(c0 - q.dly[1]);
                c2 = 32'(c1 - q.dly[2]);
                d.dly[0] = d.integ[2];
                d.dly[1] = c0;
                d.dly[2] = c1;
                d.raw = c2;
                d.valid = 1'b1;
            end
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_valid = q.valid;
    assign o_raw = q.raw;

    a_restart_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_restart |=> q.integ == '0 && q.dly == '0)
        else $error("sinc3 state not cleared on restart");
endmodule

`default_nettype wire

/* sdf_top.sv */
package sdf_pkg;
    // nominal master clock per power mode, in kHz
    localparam int MCLK_HR_KHZ = 32'h0000_2000;
    localparam int MCLK_LP_KHZ = 32'h0000_1000;
    localparam int MCLK_VLP_KHZ = 32'h0000_0800;
    localparam int REF_CLK_PERIOD_NS = 32'h0000_0008;
    localparam int MOD_CLK_DIV = 32'h0000_0002;
    localparam int CODE_W = 32'h0000_0003;
    localparam int OUT_W = 32'h0000_0018;
    localparam int S3_W = 32'h0000_0020;
    localparam int FAST_W = 32'h0000_0010;
    localparam int S1_W = 32'h0000_0024;
    localparam int RAW_W = 32'h0000_0028;
    localparam int FIFO_DEPTH = 32'h0000_0004;
    localparam logic [3:0] LOG2_BASE = 4'h7;
    localparam logic [3:0] LOG2_R64 = 4'h6;
    localparam logic [3:0] S3_MAX_LOG2 = 4'ha;
    localparam logic [5:0] S3_FIXED_EXP = 6'h1e;
    localparam logic [5:0] OUT_EXP = 6'h17;
    localparam logic [2:0] CODE_RST = 3'h0;
    localparam logic [1:0] FAST_RESULTS = 2'h2;
    // settling in master clock cycles, ratios 64 to 1024
    localparam logic [15:0] SETTLE_64 = 16'h02d8;
    localparam logic [15:0] SETTLE_128 = 16'h0358;
    localparam logic [15:0] SETTLE_256 = 16'h0458;
    localparam logic [15:0] SETTLE_512 = 16'h0658;
    localparam logic [15:0] SETTLE_1024 = 16'h0a58;
    localparam logic [OUT_W-1:0] OUT_MAX = 24'h7f_ffff;
    localparam logic [OUT_W-1:0] OUT_MIN = 24'h80_0000;

    function automatic logic [3:0] ratio_log2(input logic r64,
                                              input logic [2:0] code);
        return r64 ? LOG2_R64 : 4'(LOG2_BASE + {1'b0, code});
    endfunction

    function automatic logic [3:0] s3_log2(input logic [3:0] l);
        return (l > S3_MAX_LOG2) ? S3_MAX_LOG2 : l;
    endfunction

    function automatic logic [13:0] ratio_mask(input logic [3:0] l);
        return 14'((16'h0001 << l) - 16'h0001);
    endfunction

    // scale a sum of +-2^exp to a 24-bit fraction, saturating full scale
    function automatic logic [OUT_W-1:0] normalize(
        input logic signed [RAW_W-1:0] raw, input logic [5:0] exp);
        logic signed [47:0] t;
        t = {{8{raw[RAW_W-1]}}, raw};
        if (exp > OUT_EXP) begin
            t = t >>> (exp - OUT_EXP);
        end else begin
            t = t <<< (OUT_EXP - exp);
        end
        if (t > $signed({24'h00_0000, OUT_MAX})) begin
            return OUT_MAX;
        end
        if (t < $signed({24'hff_ffff, OUT_MIN})) begin
            return OUT_MIN;
        end
        return t[OUT_W-1:0];
    endfunction
endpackage

`timescale 1ns/1ns
`default_nettype none

module sdf_top
    import sdf_pkg::*;
#(
    parameter int SETTLE_2048 = 32'h0000_1258,
    parameter int SETTLE_4096 = 32'h0000_2258,
    parameter int SETTLE_8192 = 32'h0000_4258,
    parameter int SETTLE_16384 = 32'h0000_8258
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_mod_bit,
    input wire logic [CODE_W-1:0] i_decimation_ratio_select,
    input wire logic i_ratio64_select,
    input wire logic i_settle_restart,
    input wire logic i_sample_ready,
    output logic o_sample_valid,
    output logic [OUT_W-1:0] o_sample_data,
    output logic o_sample_ready_n,
    output logic o_sinc3_selected
);
    typedef struct packed {
        logic mod_en;
        logic [1:0] bit_sync;
        logic [CODE_W-1:0] code;
        logic r64;
        logic [13:0] fast_cnt;
        logic signed [FAST_W-1:0] fast_acc;
        logic signed [FAST_W-1:0] fast_last;
        logic [9:0] s3_cnt;
        logic signed [S1_W-1:0] s1_acc;
        logic grp_end;
        logic [1:0] conv_cnt;
        logic use_s3;
        logic res_pend;
        logic [OUT_W-1:0] res_data;
        logic [15:0] settle_left;
        logic [14:0] h_mod;
        logic [4:0] h_dump;
    } sdf_state_t;

    sdf_state_t q;
    sdf_state_t d;
    logic restart;
    logic s3_dump;
    logic s3_valid;
    logic signed [S3_W-1:0] s3_raw;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [3:0] ln;
    logic [3:0] ls3;
    logic [3:0] lm;
    logic signed [S1_W-1:0] s1_sum;
    logic signed [FAST_W-1:0] fast_next;

    function automatic logic [15:0] settle_cycles(input logic r64,
                                                  input logic [2:0] code);
        logic [3:0] l;
        l = ratio_log2(r64, code);
        unique case (l)
            4'h6: return SETTLE_64;
            4'h7: return SETTLE_128;
            4'h8: return SETTLE_256;
            4'h9: return SETTLE_512;
            4'ha: return SETTLE_1024;
            4'hb: return 16'(SETTLE_2048);
            4'hc: return 16'(SETTLE_4096);
            4'hd: return 16'(SETTLE_8192);
            default: return 16'(SETTLE_16384);
        endcase
    endfunction

    assign ln = ratio_log2(q.r64, q.code);
    assign ls3 = s3_log2(ln);
    assign lm = 4'(ln - ls3);
    // a new ratio invalidates every partial sum, so it restarts like resync
    assign restart = i_settle_restart
        || (q.code != i_decimation_ratio_select)
        || (q.r64 != i_ratio64_select);

    always_comb begin
        d = q;
        s3_dump = 1'b0;
        d.mod_en = ~q.mod_en;
        d.bit_sync = {q.bit_sync[0], i_mod_bit};
        d.code = i_decimation_ratio_select;
        d.r64 = i_ratio64_select;
        d.grp_end = 1'b0;
        fast_next = q.bit_sync[1] ? 16'(q.fast_acc + 16'sh0001)
                                  : 16'(q.fast_acc - 16'sh0001);
        s1_sum = 36'(q.s1_acc + {{4{s3_raw[S3_W-1]}}, s3_raw});
        if (q.res_pend && fifo_in_ready) begin
            d.res_pend = 1'b0;
        end
        if (s3_valid && (ln > S3_MAX_LOG2)) begin
            d.s1_acc = q.grp_end ? '0 : s1_sum;
        end
        if (q.grp_end) begin
            // unsettled results go out like any other
            d.res_pend = 1'b1;
            if (!q.use_s3) begin
                d.res_data = normalize({{24{q.fast_last[FAST_W-1]}},
                                        q.fast_last}, {2'h0, ln});
            end else if (ln > S3_MAX_LOG2) begin
                d.res_data = normalize({{4{s1_sum[S1_W-1]}}, s1_sum},
                                       6'(S3_FIXED_EXP + {2'h0, lm}));
            end else begin
                d.res_data = normalize({{8{s3_raw[S3_W-1]}}, s3_raw},
                                       6'(6'h03 * {2'h0, ls3}));
            end
            if (q.conv_cnt != FAST_RESULTS) begin
                d.conv_cnt = 2'(q.conv_cnt + 2'h1);
            end
            if (q.conv_cnt == 2'(FAST_RESULTS - 2'h1)) begin
                d.use_s3 = 1'b1;
            end
        end
        if (restart) begin
            // the path choice survives a restart; only reset brings sinc1 back
            d.fast_cnt = '0;
            d.fast_acc = '0;
            d.s3_cnt = '0;
            d.s1_acc = '0;
            d.settle_left = settle_cycles(i_ratio64_select,
                                          i_decimation_ratio_select);
        end else begin
            if (q.settle_left != 16'h0000) begin
                d.settle_left = 16'(q.settle_left - 16'h0001);
            end
            if (q.mod_en) begin
                // both paths see the same bit in the same cycle
                if (q.fast_cnt == ratio_mask(ln)) begin
                    d.fast_last = fast_next;
                    d.fast_acc = '0;
                    d.fast_cnt = '0;
                    d.grp_end = 1'b1;
                end else begin
                    d.fast_acc = fast_next;
                    d.fast_cnt = 14'(q.fast_cnt + 14'h0001);
                end
                // compare at full mask width; a call result cannot be sliced
                if ({4'h0, q.s3_cnt} == ratio_mask(ls3)) begin
                    s3_dump = 1'b1;
                    d.s3_cnt = '0;
                end else begin
                    d.s3_cnt = 10'(q.s3_cnt + 10'h001);
                end
            end
        end
        if (restart || q.grp_end) begin
            d.h_mod = '0;
            d.h_dump = '0;
        end else begin
            if (q.mod_en) begin
                d.h_mod = 15'(q.h_mod + 15'h0001);
            end
            if (s3_dump) begin
                d.h_dump = 5'(q.h_dump + 5'h01);
            end
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            q <= '0;
            q.code <= CODE_RST;
        end else begin
            q <= d;
        end
    end

    sdf_sinc3 u_sinc3 (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_restart(restart),
        .i_mod_en(q.mod_en && !restart),
        .i_bit(q.bit_sync[1]),
        .i_dump(s3_dump),
        .o_valid(s3_valid),
        .o_raw(s3_raw)
    );

    // the stream cannot stall; a result waits in res_data until taken or overwritten by the next result
    sdf_fifo #(
        .WIDTH(OUT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_in_valid(q.res_pend),
        .o_in_ready(fifo_in_ready),
        .i_in_data(q.res_data),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(i_sample_ready),
        .o_out_data(o_sample_data)
    );

    assign o_sample_valid = fifo_out_valid;
    assign o_sample_ready_n = ~fifo_out_valid;
    assign o_sinc3_selected = q.use_s3;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_mod_low_high;
        !q.mod_en ##1 q.mod_en;
    endsequence

    a_mod_half_rate: assert property (
        q.mod_en |=> s_mod_low_high)
        else $error("modulator enable not at half the master clock");
    a_group_length: assert property (
        q.grp_end |-> q.h_mod == 15'(15'h0001 << ln))
        else $error("result group length differs from the ratio");
    a_fast_first: assert property (
        q.conv_cnt != FAST_RESULTS |-> !q.use_s3)
        else $error("sinc3 selected before two conversions");
    a_sinc3_sticky: assert property (
        $rose(q.use_s3) |-> $past(q.conv_cnt) == 2'h1 ##1 q.use_s3 [*8])
        else $error("path switch not after two conversions or not kept");
    a_dumps_per_group: assert property (
        q.grp_end |-> q.h_dump == 5'(5'h01 << lm))
        else $error("sinc3 dumps per result differ from the sinc1 ratio");
    a_dump_to_valid: assert property (
        s3_dump |=> s3_valid)
        else $error("sinc3 result not one cycle after its dump");
    a_restart_clears: assert property (
        restart |=> q.fast_cnt == 14'h0000 && q.s3_cnt == 10'h000)
        else $error("restart left filter counters running");
    a_settle_load: assert property (
        restart |=> q.settle_left == settle_cycles($past(i_ratio64_select),
            $past(i_decimation_ratio_select)))
        else $error("settling count not loaded from the ratio");
    a_no_gating: assert property (
        q.grp_end && q.settle_left != 16'h0000 |=> q.res_pend)
        else $error("result held back while settling");
    a_ready_falls: assert property (
        q.res_pend && fifo_in_ready |=> !o_sample_ready_n)
        else $error("data ready did not fall after a result");

    // one step down per master clock until the interval is spent
    sequence s_settle_step;
        q.settle_left == 16'($past(q.settle_left) - 16'h0001);
    endsequence

    a_settle_countdown: assert property (
        !restart && q.settle_left != 16'h0000 |=> s_settle_step)
        else $error("settling count did not step down");
    a_path_kept: assert property (
        restart && q.use_s3 |=> q.use_s3)
        else $error("restart moved the output off the sinc3 path");
    a_direct_dump: assert property (
        s3_dump && ln <= S3_MAX_LOG2 |=> q.grp_end)
        else $error("sinc3 dump not aligned with its result group");
endmodule

`default_nettype wire

/* test_sigma_delta_decimation_filter.sv */
`timescale 1ns/1ns
`default_nettype none

module test_sigma_delta_decimation_filter
    import sdf_pkg::*;
;
    logic clk;
    logic rst;
    logic mod_bit;
    logic r64;
    logic restart;
    logic stall;
    logic settle_start;
    logic ready;
    logic valid;
    logic ready_n;
    logic s3sel;
    logic [CODE_W-1:0] code;
    logic [15:0] settle_cycles;
    logic [OUT_W-1:0] data;
    logic [1:0] mode;
    logic [1:0] ph;
    int errors;
    int n_checks;

    sdf_top #(
        .SETTLE_2048(32'h0000_0064),
        .SETTLE_4096(32'h0000_00c8),
        .SETTLE_8192(32'h0000_012c),
        .SETTLE_16384(32'h0000_0190)
    ) DUT (
        .i_ref_clk(clk),
        .i_rst(rst),
        .i_mod_bit(mod_bit),
        .i_decimation_ratio_select(code),
        .i_ratio64_select(r64),
        .i_settle_restart(restart),
        .i_sample_ready(ready),
        .o_sample_valid(valid),
        .o_sample_data(data),
        .o_sample_ready_n(ready_n),
        .o_sinc3_selected(s3sel)
    );

    sdf_host_model host (
        .i_ref_clk(clk),
        .i_rst(rst),
        .i_stall(stall),
        .i_settle_start(settle_start),
        .i_settle_cycles(settle_cycles),
        .i_sample_ready_n(ready_n),
        .i_sample_data(data),
        .o_sample_ready(ready)
    );

    always #4 clk = ~clk;

    // mode 0 alternates the consumed bits (zero mean), 1 all ones, 2 zeros
    always @(posedge clk) begin
        ph <= ph + 2'h1;
        mod_bit <= (mode == 2'h0) ? ph[1] : mode[0];
    end

    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [OUT_W-1:0] got,
                            input logic [OUT_W-1:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_range(input int got, input int lo, input int hi);
        n_checks++;
        if (got < lo || got > hi) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    // waits for a word popped after min_stamp, bounded by limit cycles
    task automatic wait_pop(input int min_stamp, input int limit);
        int n;
        int k;
        logic ok;
        ok = 1'b0;
        for (k = 0; k < limit && !ok; k++) begin
            n = host.n_got;
            @(posedge clk);
            #1;
            if (host.n_got != n && host.last_stamp > min_stamp) begin
                ok = 1'b1;
            end
        end
        chk_bit(ok, 1'b1);
    endtask

    task automatic pulse_restart(output int t0);
        @(posedge clk);
        restart <= 1'b1;
        settle_start <= 1'b1;
        @(posedge clk);
        restart <= 1'b0;
        settle_start <= 1'b0;
        #1;
        t0 = host.cyc;
    endtask

    task automatic s_reset_path();
        int t0;
        int t1;
        @(posedge clk);
        #1;
        t0 = host.cyc;
        chk_bit(s3sel, 1'b0);
        chk_bit(ready_n, 1'b1);
        wait_pop(t0, 200);
        t1 = host.last_stamp;
        chk_range(t1 - t0, 124, 140);
        chk_word(host.last_word, 24'h00_0000);
        chk_bit(s3sel, 1'b0);
        wait_pop(t1, 200);
        chk_range(host.last_stamp - t1, 128, 128);
        chk_word(host.last_word, 24'h00_0000);
        chk_bit(s3sel, 1'b1);
    endtask

    task automatic s_settle();
        int n;
        int t1;
        n = 0;
        wait_pop(host.last_stamp, 200);
        while (!host.last_settled && n < 10) begin
            n++;
            wait_pop(host.last_stamp, 200);
        end
        chk_range(n, 1, 8);
        chk_bit(host.last_settled, 1'b1);
        chk_word(host.last_word, 24'h00_0000);
        t1 = host.last_stamp;
        wait_pop(t1, 200);
        chk_range(host.last_stamp - t1, 128, 128);
        chk_word(host.last_word, 24'h00_0000);
    endtask

    task automatic s_restart();
        int t0;
        pulse_restart(t0);
        wait_pop(t0 + 6, 200);
        chk_range(host.last_stamp - t0, 120, 140);
        chk_bit(s3sel, 1'b1);
    endtask

    task automatic s_stall_fifo();
        int t0;
        int n;
        int k;
        mode <= 2'h1;
        pulse_restart(t0);
        n = 0;
        wait_pop(t0, 200);
        while (!host.last_settled && n < 12) begin
            n++;
            wait_pop(host.last_stamp, 200);
        end
        chk_word(host.last_word, 24'h7f_ffff);
        @(posedge clk);
        stall <= 1'b1;
        // six results arrive while stalled: four queue, the last pending
        repeat (808) @(posedge clk);
        #1;
        chk_bit(valid, 1'b1);
        chk_bit(ready_n, 1'b0);
        n = host.n_got;
        @(posedge clk);
        stall <= 1'b0;
        for (k = 0; k < 5; k++) begin
            wait_pop(host.last_stamp, 20);
            chk_word(host.last_word, 24'h7f_ffff);
        end
        repeat (20) @(posedge clk);
        #1;
        chk_range(host.n_got - n, 5, 5);
        chk_bit(valid, 1'b0);
        chk_bit(ready_n, 1'b1);
    endtask

    task automatic s_codes();
        int t0;
        int n;
        int k;
        mode <= 2'h2;
        for (k = 0; k < 8; k++) begin
            n = 128 << k;
            @(posedge clk);
            r64 <= 1'b0;
            code <= 3'(k);
            @(posedge clk);
            #1;
            t0 = host.cyc;
            wait_pop(t0 + 6, 2 * n + 40);
            chk_range(host.last_stamp - t0, 2 * n - 8, 2 * n + 10);
            chk_bit(s3sel, 1'b1);
        end
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        r64 = 1'b1;
        code = 3'h0;
        restart = 1'b0;
        stall = 1'b0;
        settle_start = 1'b0;
        settle_cycles = 16'h02d8;
        mode = 2'h0;
        ph = 2'h0;
        mod_bit = 1'b0;
        errors = 0;
        n_checks = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        s_reset_path();
        s_settle();
        s_restart();
        s_stall_fifo();
        s_codes();
        close_out();
    end

    // the whole run needs about 68000 cycles
    initial begin
        repeat (90000) @(posedge clk);
        errors++;
        close_out();
    end
endmodule

`default_nettype wire
